// >>> src/seq_cfg.svh
// Purpose: constants for the supply and bulk sequencer
// Assumes: 40 MHz clock
// Notes: filter count derived from a time in its own unit; limit step given in cycles
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define CLK_MHZ 40
`define BULK_FILTER_TIME_NS 25000
`define BULK_FILTER_CYCLES ((`BULK_FILTER_TIME_NS * `CLK_MHZ) / 1000)
`define DIE_LIMIT_DEG_C 130
`define LIMIT_STEP_CYCLES 64
`endif

// >>> src/seq_pkg.sv
// Purpose: types for the supply and bulk sequencer
// Assumes: nothing
// Notes: one-hot supply states
package seq_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_CHARGE = 4'h2,
    ST_RUN = 4'h4,
    ST_CYCLE = 4'h8
  } supply_state_t;
endpackage

// >>> src/bulk_filter.sv
// Purpose: brown-out comparator digital filter
// Assumes: comparator synchronous to clk
// Notes: output changes only after a full stable run
`timescale 1ns/10ps
module bulk_filter #(
  parameter int COUNT = 1000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic raw_in,
  output logic filt_q
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (ce) begin
      if (raw_in == filt_q) begin
        cnt_q <= '0;
      end else if (cnt_q == W'(COUNT - 1)) begin
        cnt_q <= '0;
        filt_q <= raw_in;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  a_filter_hold: assert property (@(posedge clk) disable iff (reset)
    (ce && (raw_in == filt_q)) |=> $stable(filt_q))
    else $error("filter output moved while input matched");
endmodule // bulk_filter

// >>> src/supply_and_bulk_sequencer.sv
// Purpose: supply, startup source and brown-out sequencing
// Assumes: comparator inputs synchronous to clk
// Notes: all outputs registered
`timescale 1ns/10ps
`include "seq_cfg.svh"

module supply_and_bulk_sequencer #(
  parameter int FILTER_CYCLES = `BULK_FILTER_CYCLES,
  parameter int LIMIT_STEP = `LIMIT_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // supply comparators
  input wire logic vcc_above_start,
  input wire logic vcc_above_stop,
  input wire logic vcc_above_reset,
  // events and conditions
  input wire logic bo_comp,
  input wire logic recovery_expired,
  input wire logic thermal_shutdown,
  input wire logic die_hot,
  input wire logic vcc_short,
  input wire logic light_load,
  input wire logic fault,
  // outputs
  output logic startup_on_q,
  output logic startup_current_low_q,
  output logic startup_current_high_q,
  output logic [3:0] startup_limit_q,
  output logic self_supply_cycling_q,
  output logic hysteresis_sink_q,
  output logic bulk_discharge_q,
  output logic switching_en_q,
  output logic front_stage_control_out_q,
  output logic bulk_ok_q
);
  import seq_pkg::*;

  // ----------------------------------------
  // filter and event edges
  // ----------------------------------------
  logic bulk_ok;
  logic bulk_ok_prev_q;
  logic tsd_prev_q;
  logic restart_evt;
  seq_pkg::supply_state_t state_q;
  seq_pkg::supply_state_t state_d;

  bulk_filter #(.COUNT(FILTER_CYCLES)) u_filter (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .raw_in(bo_comp),
    .filt_q(bulk_ok)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      bulk_ok_prev_q <= 1'b0;
      tsd_prev_q <= 1'b0;
      bulk_ok_q <= 1'b0;
    end else if (ce) begin
      bulk_ok_prev_q <= bulk_ok;
      tsd_prev_q <= thermal_shutdown;
      bulk_ok_q <= bulk_ok;
    end
  end

  // bulk_ok rise, timer expiry, thermal shutdown end
  assign restart_evt = (bulk_ok && !bulk_ok_prev_q) || recovery_expired ||
                       (tsd_prev_q && !thermal_shutdown);

  // ----------------------------------------
  // supply state machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (!thermal_shutdown) begin
          state_d = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (vcc_above_start) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!vcc_above_stop) begin
          state_d = ST_CYCLE;
        end else if (restart_evt && !vcc_above_start) begin
          state_d = ST_CYCLE;
        end
      end
      ST_CYCLE: begin
        if (vcc_above_start && !startup_on_q) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (!vcc_above_reset) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_OFF;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // startup source
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      startup_on_q <= 1'b0;
    end else if (ce) begin
      if (thermal_shutdown || vcc_above_start) begin
        startup_on_q <= 1'b0;
      end else if (state_d == ST_CHARGE || restart_evt) begin
        startup_on_q <= 1'b1;
      end else if (state_d == ST_CYCLE && !vcc_above_stop) begin
        startup_on_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      startup_current_low_q <= 1'b0;
      startup_current_high_q <= 1'b0;
    end else if (ce) begin
      startup_current_low_q <= vcc_short;
      startup_current_high_q <= !vcc_short;
    end
  end

  // progressive limit of the high level while the die is hot
  logic [$clog2(LIMIT_STEP + 1)-1:0] step_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      step_q <= '0;
      startup_limit_q <= 4'h0;
    end else if (ce) begin
      if (step_q == ($bits(step_q))'(LIMIT_STEP - 1)) begin
        step_q <= '0;
        if (die_hot && startup_limit_q != 4'hF) begin
          startup_limit_q <= startup_limit_q + 4'h1;
        end else if (!die_hot && startup_limit_q != 4'h0) begin
          startup_limit_q <= startup_limit_q - 4'h1;
        end
      end else begin
        step_q <= step_q + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // bulk pin, switching, front stage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      self_supply_cycling_q <= 1'b0;
      bulk_discharge_q <= 1'b1;
      hysteresis_sink_q <= 1'b0;
      switching_en_q <= 1'b0;
      front_stage_control_out_q <= 1'b0;
    end else if (ce) begin
      self_supply_cycling_q <= (state_d == ST_CYCLE);
      bulk_discharge_q <= (state_d == ST_OFF) || (state_d == ST_CHARGE);
      hysteresis_sink_q <= !(state_d == ST_OFF || state_d == ST_CHARGE)
                           && !bulk_ok;
      switching_en_q <= (state_d == ST_RUN) && bulk_ok;
      front_stage_control_out_q <= (state_d == ST_RUN) && !light_load
                                   && !fault;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_start_reached;
    ce && vcc_above_start;
  endsequence

  a_source_off_start: assert property (@(posedge clk) disable iff (reset)
    s_start_reached |=> !startup_on_q)
    else $error("startup source on above start threshold");
  a_no_pulse_cycle: assert property (@(posedge clk) disable iff (reset)
    self_supply_cycling_q |-> !switching_en_q)
    else $error("switching during self-supply cycling");
  a_sink_bulk_ok: assert property (@(posedge clk) disable iff (reset)
    bulk_ok_q && !bulk_discharge_q |-> !hysteresis_sink_q)
    else $error("sink on while bulk ok");
  a_discharge_sink: assert property (@(posedge clk) disable iff (reset)
    bulk_discharge_q |-> !hysteresis_sink_q)
    else $error("sink and discharge together");
  a_switch_bulk: assert property (@(posedge clk) disable iff (reset)
    switching_en_q |-> $past(bulk_ok))
    else $error("switching without bulk ok");
  a_front_low: assert property (@(posedge clk) disable iff (reset)
    (bulk_discharge_q || self_supply_cycling_q) |-> !front_stage_control_out_q)
    else $error("front stage biased before start");
  a_front_fault: assert property (@(posedge clk) disable iff (reset)
    ce && fault |=> !front_stage_control_out_q)
    else $error("front stage biased during fault");
  a_current_sel: assert property (@(posedge clk) disable iff (reset)
    startup_current_low_q |-> !startup_current_high_q)
    else $error("both startup levels selected");
endmodule // supply_and_bulk_sequencer

// >>> sim/supply_model.sv
// Purpose: supply rail model behind the sequencer
// Assumes: one rail step per clock
// Notes: rail charges from the source and sags without auxiliary bias
`timescale 1ns/10ps
module supply_model #(
  parameter int LVL_START = 15,
  parameter int LVL_STOP = 8,
  parameter int LVL_RESET = 3
) (
  // clock and rail control
  input wire logic clk,
  input wire logic source_on,
  input wire logic aux_ok,
  // comparator levels
  output logic above_start,
  output logic above_stop,
  output logic above_reset
);
  int level = 0;
  // below the reset level the rail creeps up even with the logic still asleep
  always @(negedge clk) begin
    if ((source_on || level < LVL_RESET) && level < 20) level <= level + 1;
    else if (!source_on && !aux_ok && level > 0) level <= level - 1;
  end
  assign above_start = (level >= LVL_START);
  assign above_stop = (level >= LVL_STOP);
  assign above_reset = (level >= LVL_RESET);
endmodule // supply_model

// >>> sim/supply_and_bulk_sequencer_tb.sv
// Purpose: self-checking bench for the supply and bulk sequencer
// Assumes: supply_model drives the supply comparators
// Notes: expected results queued by the driver, compared by a watcher
`timescale 1ns/10ps
module supply_and_bulk_sequencer_tb;
  localparam int FILT = 4;
  typedef struct {int idx; logic val;} note_t;
  logic clk = 0, reset = 1, ce = 1, bo_comp = 0, recovery_expired = 0, thermal_shutdown = 0;
  logic die_hot = 0, vcc_short = 0, light_load = 0, fault = 0, aux_ok = 1;
  logic above_start, above_stop, above_reset;
  logic on_q, low_q, high_q, cyc_q, sink_q, dis_q, sw_q, fs_q, ok_q;
  logic [3:0] lim_q;
  int error_cnt = 0, n_checks = 0, len;
  note_t notes[$];
  string nm[10] = '{"startup_on", "current_low", "current_high", "cycling", "sink",
    "discharge", "switching", "front_stage", "bulk_ok", "limit_active"};
  wire logic [9:0] outs = {|lim_q, ok_q, fs_q, sw_q, dis_q, sink_q, cyc_q, high_q, low_q, on_q};
  always #12.5 clk = ~clk;
  supply_model rail_u (.clk(clk), .source_on(on_q), .aux_ok(aux_ok), .above_start(above_start),
    .above_stop(above_stop), .above_reset(above_reset));
  supply_and_bulk_sequencer #(.FILTER_CYCLES(FILT), .LIMIT_STEP(2)) dut_u (.clk(clk),
    .reset(reset), .ce(ce), .vcc_above_start(above_start), .vcc_above_stop(above_stop),
    .vcc_above_reset(above_reset), .bo_comp(bo_comp), .recovery_expired(recovery_expired),
    .thermal_shutdown(thermal_shutdown), .die_hot(die_hot), .vcc_short(vcc_short),
    .light_load(light_load), .fault(fault), .startup_on_q(on_q), .startup_current_low_q(low_q),
    .startup_current_high_q(high_q), .startup_limit_q(lim_q), .self_supply_cycling_q(cyc_q),
    .hysteresis_sink_q(sink_q), .bulk_discharge_q(dis_q), .switching_en_q(sw_q),
    .front_stage_control_out_q(fs_q), .bulk_ok_q(ok_q));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic note(int i, logic v);
    notes.push_back('{i, v});
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_for(int i, logic v);
    int k;
    k = 0;
    while (outs[i] !== v && k < 200) begin
      @(negedge clk);
      k++;
    end
    note(i, v);
  endtask
  task automatic compare(note_t n);
    n_checks++;
    if (outs[n.idx] !== n.val) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm[n.idx], n.val, outs[n.idx]);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watcher compares settled outputs at the edge after each note
  always @(posedge clk) begin : watch
    while (notes.size() > 0) compare(notes.pop_front());
  end
  initial begin
    #(25 * 6000);
    error_cnt++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h4CB5108C));
    cyc(4);
    note(5, 1);
    note(0, 0);
    note(8, 0);
    reset = 0;
    wait_for(0, 1);
    note(5, 1);
    wait_for(0, 0);
    note(5, 0);
    note(4, 1);
    len = 1 + $urandom % (FILT - 1);
    bo_comp = 1;
    cyc(len);
    bo_comp = 0;
    cyc(FILT + 3);
    note(8, 0);
    bo_comp = 1;
    cyc(FILT);
    note(8, 0);
    cyc(2);
    note(8, 1);
    cyc(2);
    note(6, 1);
    note(4, 0);
    note(7, 1);
    light_load = 1;
    cyc(2);
    note(7, 0);
    light_load = 0;
    fault = 1;
    cyc(2);
    note(7, 0);
    fault = 0;
    cyc(2);
    note(7, 1);
    // clock enable low: filter, front stage and switching must all hold
    ce = 0;
    bo_comp = 0;
    light_load = 1;
    cyc(FILT + 3);
    note(8, 1);
    note(7, 1);
    note(6, 1);
    ce = 1;
    light_load = 0;
    bo_comp = 0;
    cyc(FILT + 3);
    note(8, 0);
    note(6, 0);
    note(4, 1);
    aux_ok = 0;
    wait_for(3, 1);
    note(7, 0);
    note(6, 0);
    vcc_short = 1;
    wait_for(0, 1);
    // the level select registers one edge after the input changes
    cyc(1);
    note(1, 1);
    note(2, 0);
    vcc_short = 0;
    die_hot = 1;
    wait_for(2, 1);
    wait_for(9, 1);
    thermal_shutdown = 1;
    cyc(3);
    note(0, 0);
    thermal_shutdown = 0;
    wait_for(0, 1);
    wait_for(0, 0);
    // rail now sags above the stop level with the source off
    cyc(2);
    recovery_expired = 1;
    cyc(1);
    recovery_expired = 0;
    note(0, 1);
    cyc(2);
    end_sim;
  end
endmodule // supply_and_bulk_sequencer_tb
